/* verilog/swlm_write_lane_mask.sv */
// burst sram write lane masking core with fifo, read port and apb
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "swlm_defines.svh"

//------------------------------------------------------------------------
// swlm_fifo: synchronous fifo, depth must be a power of two
//------------------------------------------------------------------------
module swlm_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// filling side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	// draining side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	// fill level
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];        // word storage
	logic [AW-1:0]    wr_ptr_reg;           // next slot to fill
	logic [AW-1:0]    rd_ptr_reg;           // next slot to drain
	logic [AW:0]      count_reg;            // words held
	logic             push;                 // accepted write
	logic             pop;                  // accepted read

	// honest full and empty from the count
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = store[rd_ptr_reg];
	assign level     = count_reg;

	// storage write, no reset needed on data
	always_ff @(posedge clk)
	begin
		if (push)
			store[wr_ptr_reg] <= in_data;
	end

	// pointers and count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//------------------------------------------------------------------------
// swlm_write_lane_mask: top of the block
//------------------------------------------------------------------------
module swlm_write_lane_mask
(
	// apb slave
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// input timing clock pair, sampled as levels
	input  wire logic                       k,
	input  wire logic                       k_n,
	// output timing clock pair, sampled as levels
	input  wire logic                       c,
	input  wire logic                       c_n,
	// write port
	input  wire logic                       write_port_select_n,
	input  wire logic [`SWLM_ADDR_W-1:0]    wr_addr,
	input  wire logic [`SWLM_DATA_W-1:0]    d,
	input  wire logic [`SWLM_LANES-1:0]     byte_lane_mask_n,
	output logic                            write_ready,
	// read port
	input  wire logic                       read_port_select_n,
	input  wire logic [`SWLM_ADDR_W-1:0]    rd_addr,
	output logic [`SWLM_DATA_W-1:0]         q,
	output logic                            q_oe
);
	localparam int DW = `SWLM_DATA_W;
	localparam int AW = `SWLM_ADDR_W;
	localparam int LN = `SWLM_LANES;

	//--------------------------------------------------------------------
	// helper functions
	//--------------------------------------------------------------------

	// per-bit store enable from organisation and active-low lane selects
	function automatic logic [DW-1:0] lane_enable(
		input swlm_pkg::swlm_org_t org,
		input logic [LN-1:0]       mask_n
	);
		logic [DW-1:0] en;
		en = '0;
		case (org)
			swlm_pkg::SWLM_ORG_X8:
			begin
				en[3:0] = {4{~mask_n[0]}};
				en[7:4] = {4{~mask_n[1]}};
			end
			swlm_pkg::SWLM_ORG_X9:
				en[8:0] = {9{~mask_n[0]}};
			swlm_pkg::SWLM_ORG_X18:
			begin
				en[8:0]  = {9{~mask_n[0]}};
				en[17:9] = {9{~mask_n[1]}};
			end
			swlm_pkg::SWLM_ORG_X36:
				for (int i = 0; i < LN; i++)
					en[i*9 +: 9] = {9{~mask_n[i]}};
			default:
				en = '0;
		endcase
		return en;
	endfunction

	// keep unselected bits, take selected ones; no enable keeps all
	function automatic logic [DW-1:0] merge(
		input logic [DW-1:0] old_w,
		input logic [DW-1:0] new_w,
		input logic [DW-1:0] en
	);
		return (old_w & ~en) | (new_w & en);
	endfunction

	//--------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------
	logic [DW-1:0]      array [2**(AW+1)];  // two words per location
	logic [3:0]         ctrl_reg;           // org, single clock, hold
	logic [AW:0]        peek_sel_reg;       // word picked for peek
	logic [7:0]         drop_reg;           // bursts lost to full fifo
	logic               k_q_reg;            // last sampled k
	logic               kn_q_reg;           // last sampled k_n
	logic               c_q_reg;            // last sampled c
	logic               cn_q_reg;           // last sampled c_n
	logic               wpend_reg;          // first beat held
	logic [DW-1:0]      beat0_reg;          // first beat data
	logic [LN-1:0]      mask0_reg;          // first beat lane selects
	logic               push_reg;           // burst ready for fifo
	logic [`SWLM_FIFO_W-1:0] burst_reg;     // packed burst
	swlm_pkg::swlm_rd_t rd_state_reg;       // read sequencer
	swlm_pkg::swlm_rd_t rd_state_next;
	logic [AW-1:0]      raddr_reg;          // latched read address
	logic [DW-1:0]      q_reg;              // read data out
	logic               q_oe_reg;           // read data enable
	logic               write_ready_reg;    // fifo room, registered
	logic [31:0]        prdata_reg;
	logic               pready_reg;
	logic               pslverr_reg;

	//--------------------------------------------------------------------
	// decode
	//--------------------------------------------------------------------
	wire swlm_pkg::swlm_org_t org =
		swlm_pkg::swlm_org_t'(ctrl_reg[`SWLM_CTRL_ORG_LSB +: 2]);
	wire single_clk = ctrl_reg[`SWLM_CTRL_SINGLE];
	wire hold       = ctrl_reg[`SWLM_CTRL_HOLD];
	wire k_rise     = k & ~k_q_reg;
	wire kn_rise    = k_n & ~kn_q_reg;
	// output clock edges fall back to the input pair in single mode
	wire o_rise     = single_clk ? k_rise : (c & ~c_q_reg);
	wire on_rise    = single_clk ? kn_rise : (c_n & ~cn_q_reg);
	wire wr_start   = k_rise & ~write_port_select_n;
	wire wr_second  = kn_rise & wpend_reg;
	wire rd_start   = k_rise & ~read_port_select_n &
	                  (rd_state_reg == swlm_pkg::SWLM_RD_IDLE);

	// fifo wiring
	wire                    f_in_ready;
	wire                    f_out_valid;
	wire [`SWLM_FIFO_W-1:0] f_out_data;
	wire [3:0]              f_level;
	wire                    commit = f_out_valid & ~hold;

	// fifo word fields: addr, mask1, beat1, mask0, beat0
	wire [DW-1:0] c_beat0 = f_out_data[DW-1:0];
	wire [LN-1:0] c_mask0 = f_out_data[DW +: LN];
	wire [DW-1:0] c_beat1 = f_out_data[DW+LN +: DW];
	wire [LN-1:0] c_mask1 = f_out_data[2*DW+LN +: LN];
	wire [AW-1:0] c_addr  = f_out_data[2*DW+2*LN +: AW];
	wire [AW:0]   c_a0    = {c_addr, 1'b0};
	wire [AW:0]   c_a1    = {c_addr, 1'b1};

	// apb phases
	wire apb_first = psel & penable & ~pready_reg;
	wire apb_done  = psel & penable & pready_reg;
	wire hit_ctrl  = (paddr == `SWLM_OFF_CTRL);
	wire hit_stat  = (paddr == `SWLM_OFF_STATUS);
	wire hit_pa    = (paddr == `SWLM_OFF_PEEKA);
	wire hit_pd    = (paddr == `SWLM_OFF_PEEKD);
	wire hit_any   = hit_ctrl | hit_stat | hit_pa | hit_pd;

	wire [31:0] status_w = {14'h0000, rd_state_reg != swlm_pkg::SWLM_RD_IDLE,
	                        wpend_reg, drop_reg, 4'h0, f_level};
	wire [31:0] rd_mux   =
		hit_ctrl ? {28'h000_0000, ctrl_reg} :
		hit_stat ? status_w :
		hit_pa   ? {27'h000_0000, peek_sel_reg} :
		hit_pd   ? array[peek_sel_reg][31:0] : 32'h0000_0000;

	//--------------------------------------------------------------------
	// burst fifo between pin capture and array commit
	//--------------------------------------------------------------------
	swlm_fifo
	#(
		.WIDTH (`SWLM_FIFO_W),
		.DEPTH (`SWLM_FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (pclk),
		.rst_n     (presetn),
		.in_valid  (push_reg),
		.in_ready  (f_in_ready),
		.in_data   (burst_reg),
		.out_valid (f_out_valid),
		.out_ready (~hold),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	//--------------------------------------------------------------------
	// pin edge sampling
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			k_q_reg  <= 1'b0;
			kn_q_reg <= 1'b0;
			c_q_reg  <= 1'b0;
			cn_q_reg <= 1'b0;
		end
		else
		begin
			k_q_reg  <= k;
			kn_q_reg <= k_n;
			c_q_reg  <= c;
			cn_q_reg <= c_n;
		end
	end

	//--------------------------------------------------------------------
	// write capture: beat and mask per input clock edge
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wpend_reg <= 1'b0;
			beat0_reg <= '0;
			mask0_reg <= '1;
			push_reg  <= 1'b0;
			burst_reg <= '0;
			drop_reg  <= 8'h00;
		end
		else
		begin
			push_reg <= 1'b0;
			if (wr_start)
			begin
				wpend_reg <= 1'b1;
				beat0_reg <= d;
				mask0_reg <= byte_lane_mask_n;
			end
			else if (wr_second)
			begin
				wpend_reg <= 1'b0;
				// second beat, its own mask, and the address
				burst_reg <= {wr_addr, byte_lane_mask_n, d,
				              mask0_reg, beat0_reg};
				push_reg  <= 1'b1;
			end
			// a full fifo loses the burst; count it, saturating
			if (push_reg && !f_in_ready && drop_reg != 8'hFF)
				drop_reg <= drop_reg + 8'h01;
		end
	end

	//--------------------------------------------------------------------
	// array commit: both beats in one update
	//--------------------------------------------------------------------
	always_ff @(posedge pclk)
	begin
		if (commit)
		begin
			array[c_a0] <= merge(array[c_a0], c_beat0,
			                     lane_enable(org, c_mask0));
			array[c_a1] <= merge(array[c_a1], c_beat1,
			                     lane_enable(org, c_mask1));
		end
	end

	//--------------------------------------------------------------------
	// read sequencer
	//--------------------------------------------------------------------
	always_comb
	begin
		rd_state_next = rd_state_reg;
		case (rd_state_reg)
			swlm_pkg::SWLM_RD_IDLE:
				if (rd_start)
					rd_state_next = swlm_pkg::SWLM_RD_ARM;
			swlm_pkg::SWLM_RD_ARM:
				if (o_rise)
					rd_state_next = swlm_pkg::SWLM_RD_B0;
			swlm_pkg::SWLM_RD_B0:
				if (on_rise)
					rd_state_next = swlm_pkg::SWLM_RD_B1;
			swlm_pkg::SWLM_RD_B1:
				if (o_rise)
					rd_state_next = swlm_pkg::SWLM_RD_TAIL;
			swlm_pkg::SWLM_RD_TAIL:
				if (on_rise)
					rd_state_next = swlm_pkg::SWLM_RD_IDLE;
			default:
				rd_state_next = swlm_pkg::SWLM_RD_IDLE;
		endcase
	end

	// read data and enable follow c and c_n, or k and k_n in single clock mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_state_reg <= swlm_pkg::SWLM_RD_IDLE;
			raddr_reg    <= '0;
			q_reg        <= '0;
			q_oe_reg     <= 1'b0;
		end
		else
		begin
			rd_state_reg <= rd_state_next;
			if (rd_start)
				raddr_reg <= rd_addr;
			if (rd_state_reg == swlm_pkg::SWLM_RD_B0 && on_rise)
			begin
				q_reg    <= array[{raddr_reg, 1'b0}];
				q_oe_reg <= 1'b1;
			end
			else if (rd_state_reg == swlm_pkg::SWLM_RD_B1 && o_rise)
				q_reg    <= array[{raddr_reg, 1'b1}];
			else if (rd_state_reg == swlm_pkg::SWLM_RD_TAIL && on_rise)
				q_oe_reg <= 1'b0;
		end
	end

	//--------------------------------------------------------------------
	// apb slave: one wait state, write lands on the pready edge
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg        <= `SWLM_CTRL_RESET;
			peek_sel_reg    <= '0;
			prdata_reg      <= 32'h0000_0000;
			pready_reg      <= 1'b0;
			pslverr_reg     <= 1'b0;
			write_ready_reg <= 1'b0;
		end
		else
		begin
			write_ready_reg <= f_in_ready;
			pready_reg      <= apb_first;
			if (apb_first)
			begin
				prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_reg <= ~hit_any;
			end
			else
				pslverr_reg <= 1'b0;
			if (apb_done && pwrite && hit_ctrl)
				ctrl_reg <= pwdata[3:0];
			if (apb_done && pwrite && hit_pa)
				peek_sel_reg <= pwdata[AW:0];
		end
	end

	//--------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------
	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign q           = q_reg;
	assign q_oe        = q_oe_reg;
	assign write_ready = write_ready_reg;
endmodule

/* verilog/swlm_defines.svh */
// constants for the sram write lane mask block
//------------------------------------------------------------------------
// Contract
//------------------------------------------------------------------------
`ifndef SWLM_DEFINES_SVH
`define SWLM_DEFINES_SVH

// widths and depths
`define SWLM_DATA_W      36
`define SWLM_LANES       4
`define SWLM_ADDR_W      4
`define SWLM_FIFO_DEPTH  8
`define SWLM_FIFO_W      84

// apb register byte offsets
`define SWLM_OFF_CTRL    12'h000
`define SWLM_OFF_STATUS  12'h004
`define SWLM_OFF_PEEKA   12'h008
`define SWLM_OFF_PEEKD   12'h00C

// control register fields
`define SWLM_CTRL_ORG_LSB  0
`define SWLM_CTRL_SINGLE   2
`define SWLM_CTRL_HOLD     3
`define SWLM_CTRL_RESET    4'h3

// status register fields
`define SWLM_STAT_LVL_LSB  0
`define SWLM_STAT_DROP_LSB 8
`define SWLM_STAT_WPEND    16
`define SWLM_STAT_RBUSY    17

`endif

/* verilog/swlm_pkg.sv */
// types shared by the sram write lane mask block
package swlm_pkg;
	// data organisation of the write port
	typedef enum logic [1:0]
	{
		SWLM_ORG_X8  = 2'b00,
		SWLM_ORG_X9  = 2'b01,
		SWLM_ORG_X18 = 2'b10,
		SWLM_ORG_X36 = 2'b11
	} swlm_org_t;

	// read port sequencing
	typedef enum logic [2:0]
	{
		SWLM_RD_IDLE = 3'b000,
		SWLM_RD_ARM  = 3'b001,
		SWLM_RD_B0   = 3'b010,
		SWLM_RD_B1   = 3'b011,
		SWLM_RD_TAIL = 3'b100
	} swlm_rd_t;
endpackage

/* tb/swlm_write_lane_mask_assertions.sv */
// checker of apb answers and output pins of the lane mask block
`timescale 1ns/1ps
`include "swlm_defines.svh"
//--------
// port checker
//--------
module swlm_write_lane_mask_checker
(
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        k,
	input wire logic        k_n,
	input wire logic        c,
	input wire logic        c_n,
	input wire logic        write_ready,
	input wire logic        read_port_select_n,
	input wire logic [35:0] q,
	input wire logic        q_oe
);
	// single domain, silent in reset
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// exactly one wait state
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait)
		else $error("pready not after one wait state");

	// answer lasts one cycle
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("pready held too long");

	// answer only inside an access
	property p_cause;
		pready |-> $past(psel && penable);
	endproperty
	a_cause: assert property (p_cause)
		else $error("pready without access");

	// refused access returns zero
	property p_errdata;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_errdata: assert property (p_errdata)
		else $error("pslverr without pready or zero data");

	// mapped control never refused
	property p_mapped;
		pready && paddr == `SWLM_OFF_CTRL |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped)
		else $error("control access refused");

	// unmapped space from 12'h010 up always refused
	property p_unmapped;
		pready && paddr >= 12'h010 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access accepted");

	// fifo reports room right after reset
	property p_wake;
		$rose(presetn) |=> write_ready;
	endproperty
	a_wake: assert property (p_wake)
		else $error("write_ready low after reset");

	// no read since reset keeps outputs undriven
	property p_hiz;
		$rose(presetn) ##1 read_port_select_n [*6] |-> !q_oe;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("q driven without read");

	// read data moves only after a clock pin was high
	property p_qhold;
		$changed(q) |-> $past(c || c_n || k || k_n);
	endproperty
	a_qhold: assert property (p_qhold)
		else $error("q changed without output clock");
endmodule

bind swlm_write_lane_mask swlm_write_lane_mask_checker u_chk
(
	.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .k, .k_n, .c, .c_n, .write_ready,
	.read_port_select_n, .q, .q_oe
);

/* tb/swlm_ctrl_model.sv */
// memory controller model driving write and read bursts
`timescale 1ns/1ps
`include "swlm_defines.svh"
//--------
// write and read burst driver
//--------
module swlm_ctrl_model
(
	// timing
	input wire logic                    pclk,
	// write port pins
	output logic                        k,
	output logic                        k_n,
	output logic                        write_port_select_n,
	output logic [`SWLM_ADDR_W-1:0]     wr_addr,
	output logic [`SWLM_DATA_W-1:0]     d,
	output logic [`SWLM_LANES-1:0]      byte_lane_mask_n,
	// read port pins
	output logic                        c,
	output logic                        c_n,
	output logic                        read_port_select_n,
	output logic [`SWLM_ADDR_W-1:0]     rd_addr
);
	// idle: clock pair stopped at equal levels
	initial
	begin
		k = 1'h0;
		k_n = 1'h0;
		write_port_select_n = 1'h1;
		wr_addr = 4'h0;
		d = 36'h0;
		byte_lane_mask_n = 4'hF;
		c = 1'h0;
		c_n = 1'h0;
		read_port_select_n = 1'h1;
		rd_addr = 4'h0;
	end

	// one two-beat burst, each beat's pin levels held two cycles
	task burst(input logic [3:0] a, input logic [35:0] b0,
		input logic [3:0] m0, input logic [35:0] b1,
		input logic [3:0] m1);
		@(posedge pclk);
		k <= 1'h1;
		write_port_select_n <= 1'h0;
		d <= b0;
		byte_lane_mask_n <= m0;
		repeat (2) @(posedge pclk);
		k <= 1'h0;
		write_port_select_n <= 1'h1;
		d <= ~b0;
		@(posedge pclk);
		k_n <= 1'h1;
		wr_addr <= a;
		d <= b1;
		byte_lane_mask_n <= m1;
		repeat (2) @(posedge pclk);
		k_n <= 1'h0;
		wr_addr <= ~a;
		d <= ~b1;
		byte_lane_mask_n <= ~m1;
	endtask

	// one read burst, then four output clock edges: c, c_n, c, c_n
	// (k, k_n, k, k_n when one is set, for single clock mode)
	task read(input logic [3:0] a, input logic one);
		@(posedge pclk);
		k <= 1'h1;
		read_port_select_n <= 1'h0;
		rd_addr <= a;
		repeat (2) @(posedge pclk);
		k <= 1'h0;
		read_port_select_n <= 1'h1;
		rd_addr <= ~a;
		for (int j = 0; j < 4; j++)
		begin
			@(posedge pclk);
			{k_n, k, c_n, c} <= 4'h1 << {one, j[0]};
			repeat (2) @(posedge pclk);
			{k_n, k, c_n, c} <= 4'h0;
		end
	endtask
endmodule

/* tb/test_sram_write_lane_mask.sv */
// self-checking bench of the lane mask block
`timescale 1ns/1ps
`include "swlm_defines.svh"
`define CHK(nm, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("wrong value %s expected %h seen %h", nm, e, g); \
		end \
	end
//--------
// bench top
//--------
module test_sram_write_lane_mask;
	// one row: organisation, masks, expected words
	typedef struct
	{
		logic [1:0]  org;
		logic [3:0]  m0;
		logic [3:0]  m1;
		logic [31:0] e0;
		logic [31:0] e1;
	} swlm_row_t;
	// apb and pins
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        k;
	logic        k_n;
	logic        write_port_select_n;
	logic [3:0]  wr_addr;
	logic [35:0] d;
	logic [3:0]  byte_lane_mask_n;
	logic        write_ready;
	logic        c;
	logic        c_n;
	logic        read_port_select_n;
	logic [3:0]  rd_addr;
	logic [35:0] q;
	logic        q_oe;
	// bookkeeping
	int          mismatches;
	int          n_checks;
	logic [31:0] rd;
	logic        er;
	int          i;
	int          n;
	swlm_row_t   rows [8] = '{
		'{2'h0, 4'hE, 4'hD, 32'h0000_000F, 32'h0000_00F0},
		'{2'h0, 4'hC, 4'hF, 32'h0000_00FF, 32'h0000_0000},
		'{2'h1, 4'hE, 4'hF, 32'h0000_01FF, 32'h0000_0000},
		'{2'h2, 4'hC, 4'hE, 32'h0003_FFFF, 32'h0000_01FF},
		'{2'h2, 4'hD, 4'hF, 32'h0003_FE00, 32'h0000_0000},
		'{2'h3, 4'hB, 4'h7, 32'h07FC_0000, 32'hF800_0000},
		'{2'h3, 4'hE, 4'hD, 32'h0000_01FF, 32'h0003_FE00},
		'{2'h3, 4'h0, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

	// design and the controller model driving both of its ports
	swlm_write_lane_mask DUT
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .k, .k_n, .c, .c_n,
		.write_port_select_n, .wr_addr, .d, .byte_lane_mask_n,
		.write_ready, .read_port_select_n, .rd_addr,
		.q, .q_oe
	);
	swlm_ctrl_model u_ctl
	(
		.pclk, .k, .k_n, .write_port_select_n, .wr_addr, .d,
		.byte_lane_mask_n, .c, .c_n, .read_port_select_n, .rd_addr
	);

	// 50 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	// print verdict and stop
	task finish_test;
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one apb transfer, waits for pready
	task apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		int t;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'h1 && t < 50);
		if (pready !== 1'h1)
			mismatches++;
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// read one array word through the peek window
	task peek(input logic [4:0] idx, input logic [31:0] e);
		apb(1'h1, `SWLM_OFF_PEEKA, {27'h0, idx}, rd, er);
		apb(1'h0, `SWLM_OFF_PEEKD, 32'h0, rd, er);
		`CHK("word", e, rd);
	endtask

	// one read burst, each word checked while it stands on q
	task rd_check(input logic [3:0] a, input logic one,
		input logic [35:0] w0, input logic [35:0] w1);
		fork
			u_ctl.read(a, one);
			begin
				repeat (9) @(posedge pclk);
				`CHK("q_oe", 1'h1, q_oe);
				`CHK("q", w0, q);
				repeat (3) @(posedge pclk);
				`CHK("q", w1, q);
			end
		join
		`CHK("q_oe", 1'h0, q_oe);
	endtask

	// hang guard
	initial
	begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		finish_test;
	end

	// main sequence
	initial
	begin
		mismatches = 0;
		n_checks = 0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		// fill word with a pattern in x36, then write its inverse
		// masked in row mode: only enabled bits may flip
		for (i = 0; i < 8; i++)
		begin
			apb(1'h1, `SWLM_OFF_CTRL, 32'h0000_0003, rd, er);
			u_ctl.burst(i[3:0], 36'hA_A5A5_A5A5, 4'h0,
				36'hA_A5A5_A5A5, 4'h0);
			apb(1'h1, `SWLM_OFF_CTRL, {30'h0, rows[i].org}, rd, er);
			u_ctl.burst(i[3:0], 36'h5_5A5A_5A5A, rows[i].m0,
				36'h5_5A5A_5A5A, rows[i].m1);
			peek({i[3:0], 1'h0}, 32'hA5A5_A5A5 ^ rows[i].e0);
			peek({i[3:0], 1'h1}, 32'hA5A5_A5A5 ^ rows[i].e1);
		end
		// stalled drain: fill until a burst is dropped
		apb(1'h1, `SWLM_OFF_CTRL, 32'h0000_000B, rd, er);
		for (i = 0; i < 9; i++)
			u_ctl.burst(4'hF, {32'h0, i[3:0]}, 4'h0, 36'h0, 4'h0);
		`CHK("ready", 1'h0, write_ready);
		apb(1'h0, `SWLM_OFF_STATUS, 32'h0, rd, er);
		`CHK("status", 32'h0000_0108, rd);
		apb(1'h1, `SWLM_OFF_CTRL, 32'h0000_0003, rd, er);
		n = 0;
		do
		begin
			apb(1'h0, `SWLM_OFF_STATUS, 32'h0, rd, er);
			n++;
		end
		while (rd[3:0] !== 4'h0 && n < 20);
		`CHK("status", 32'h0000_0100, rd);
		peek(5'h1E, 32'h0000_0007);
		// second reset in mid-run
		apb(1'h1, `SWLM_OFF_CTRL, 32'h0000_0008, rd, er);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		`CHK("ready", 1'h1, write_ready);
		`CHK("oe", 1'h0, q_oe);
		apb(1'h0, `SWLM_OFF_CTRL, 32'h0, rd, er);
		`CHK("ctrl", 32'h0000_0003, rd);
		apb(1'h0, `SWLM_OFF_STATUS, 32'h0, rd, er);
		`CHK("status", 32'h0000_0000, rd);
		apb(1'h0, 12'h010, 32'h0, rd, er);
		`CHK("err", 1'h1, er);
		`CHK("rdata", 32'h0, rd);
		// read bursts: output clock pair, then single clock mode
		rd_check(4'h7, 1'h0, 36'h5_5A5A_5A5A, 36'hA_A5A5_A5A5);
		apb(1'h1, `SWLM_OFF_CTRL, 32'h0000_0007, rd, er);
		rd_check(4'h5, 1'h1, 36'hA_A259_A5A5, 36'h5_5DA5_A5A5);
		finish_test;
	end
endmodule
